// *** verilog/scw_defines.svh ***
// constants for the serial wake/sync block
// assumes inclusion by bare name from the design files
`ifndef SCW_DEFINES_SVH
`define SCW_DEFINES_SVH
`define SCW_OFF_BAUD 8'h0D
`define SCW_OFF_CTL1 8'h0E
`define SCW_OFF_CTL2 8'h0F
`define SCW_OFF_FLAGS 8'h10
`define SCW_OFF_DATA 8'h11
`define SCW_C1_R8 7
`define SCW_C1_T8 6
`define SCW_C1_NINE 4
`define SCW_C1_WAKE 3
`define SCW_C1_POL 2
`define SCW_C1_PHA 1
`define SCW_C1_LBP 0
`define SCW_C2_TE 3
`define SCW_C2_RE 2
`define SCW_C2_SLEEP 1
`define SCW_C2_BRK 0
`define SCW_F_TXEMPTY 7
`define SCW_F_TC 6
`define SCW_F_FULL 5
`define SCW_F_IDLE 4
`define SCW_F_OVR 3
`define SCW_F_NOISE 2
`define SCW_F_FERR 1
`define SCW_RST_DATA 8'h00
`define SCW_RST_BAUD 8'h00
`define SCW_RT_LAST 4'hF
`define SCW_RT_HALF 4'h8
`define SCW_RT_V3 4'h2
`define SCW_RT_V7 4'h6
`define SCW_RT_S8 4'h7
`define SCW_RT_S10 4'h9
`define SCW_IDLE_BITS8 8'h0A
`define SCW_IDLE_BITS9 8'h0B
`endif

// *** verilog/scw_pkg.sv ***
// types shared by the serial wake/sync block
// assumes nothing beyond a SystemVerilog compiler
package scw_pkg;
    typedef enum logic [2:0] {
        RX_IDLE = 3'h0, RX_VERIFY = 3'h1, RX_BITS = 3'h3,
        RX_HOLD = 3'h2, RX_WAIT_HIGH = 3'h6
    } scw_rx_state_t;
    typedef enum logic [2:0] {
        TX_OFF = 3'h0, TX_PRE = 3'h1, TX_IDLE = 3'h3, TX_START = 3'h2,
        TX_DATA = 3'h6, TX_STOP = 3'h7, TX_BREAK = 3'h5
    } scw_tx_state_t;
    function automatic logic scw_maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : scw_maj3
endpackage : scw_pkg

// *** verilog/scw_stream_if.sv ***
// valid/ready word carrier between the block's own modules
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface scw_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : scw_stream_if

// *** verilog/scw_fifo.sv ***
// transmit holding fifo with registered head word
// assumes synchronous use on clk_in
`timescale 1ns/1ps
module scw_fifo
    import scw_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
)(
    input wire logic clk_in,
    input wire logic reset_in,
    scw_stream_if.snk in_if,
    scw_stream_if.src out_if
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("scw_fifo: depth must be a power of two, width positive");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] head;
    logic push;
    logic pop;
    logic [AW-1:0] next_rd;
    assign in_if.ready = (count != (AW+1)'(DEPTH));
    assign out_if.valid = (count != '0);
    assign out_if.data = head;
    assign push = in_if.valid & in_if.ready;
    assign pop = out_if.valid & out_if.ready;
    assign next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem[wr_ptr] <= in_if.data;
    end
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            head <= '0;
        end
        else
        begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= next_rd;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
            head <= (push && wr_ptr == next_rd) ? in_if.data : mem[next_rd];
        end
    end
endmodule : scw_fifo

// *** verilog/scw_baud.sv ***
// sample tick generator, one pulse every div_in+1 clocks
// assumes div_in only changes while both directions are off
`timescale 1ns/1ps
module scw_baud
    import scw_pkg::*;
#(
    parameter int DIV_W = 8
)(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [DIV_W-1:0] div_in,
    output logic tick_out
);
    initial
    begin
        if (DIV_W < 1)
            $error("scw_baud: divider width must be positive");
    end
    logic [DIV_W-1:0] cnt;
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cnt <= '0;
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= (cnt == div_in);
            cnt <= (cnt == div_in) ? '0 : cnt + 1'b1;
        end
    end
endmodule : scw_baud

// *** verilog/scw_core.sv ***
// serial wake/sync block: registers, receiver, transmitter
// assumes a synchronous internal bus and synchronous line inputs
//
// Functional notes
// - sleep keeps receive flags from setting, except on the address frame that wakes
// - wake clears sleep; software may too
// - idle wake after ten/eleven high bits
// - address wake on set top data bit
// - sixteen samples per bit, start-synchronised
// - majority of samples eight nine ten
// - noise when three samples disagree
// - start needs two low of three checks
// - noise when a start check reads high
// - framing error: force stop, delay start
// - break: wait for high before start
// - transmit bit is sixteen sample ticks
// - no sync clock on start, stop
// - final bit pulse enable in bit 0
// - polarity bit 2, phase bit 1
// - sync clock quiet idle, preamble, break
// - transmitter off floats data and clock
// - data address: read rx, write tx
// - full flag set on receive transfer
// - tx load only after frame completes
// - low start, lsb first, high stop
// - polarity sets sync clock rest level
// - phase picks pulse start or middle
// - seven to nine pulses per frame
`timescale 1ns/1ps
`include "scw_defines.svh"
module scw_core
    import scw_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int DIV_W = 8
)(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    output logic wr_ready_out,
    input wire logic rx_serial_in,
    output logic tx_data_out,
    output logic tx_data_oe_out,
    output logic sync_clk_out,
    output logic sync_clk_oe_out
);
    initial
    begin
        if (DIV_W > 8 || DIV_W < 1)
            $error("scw_core: divider width must be 1 to 8");
    end
    // ********************************
    // registers
    // ********************************
    logic nine_bit, wake_addr, sync_polarity, sync_phase;
    logic final_bit_pulse_enable, t8, r8;
    logic tx_enable, rx_enable, receiver_sleep, send_break;
    logic rx_full_flag, idle_flag, overrun_flag, noise_flag;
    logic framing_error_flag, tc_flag, pre_req;
    logic [DIV_W-1:0] baud_div;
    logic [7:0] rx_holding;
    logic tick;
    logic wr_data, wr_c1, wr_c2, rd_data;
    logic set_full, set_ovr, set_noise, set_fe, set_idle, set_tc;
    logic wake_now;
    logic [7:0] nbits;
    assign wr_data = wr_in && addr_in == `SCW_OFF_DATA;
    assign wr_c1 = wr_in && addr_in == `SCW_OFF_CTL1;
    assign wr_c2 = wr_in && addr_in == `SCW_OFF_CTL2;
    assign rd_data = rd_in && addr_in == `SCW_OFF_DATA;
    assign nbits = nine_bit ? 8'h09 : 8'h08;
    scw_stream_if #(.W(9)) push_if ();
    scw_stream_if #(.W(9)) pop_if ();
    assign push_if.valid = wr_data;
    assign push_if.data = {t8, wdata_in};
    scw_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_if(push_if),
        .out_if(pop_if)
    );
    scw_baud #(.DIV_W(DIV_W)) u_baud (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .div_in(baud_div),
        .tick_out(tick)
    );
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            nine_bit <= 1'b0;
            wake_addr <= 1'b0;
            sync_polarity <= 1'b0;
            sync_phase <= 1'b0;
            final_bit_pulse_enable <= 1'b0;
            t8 <= 1'b0;
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
            send_break <= 1'b0;
            baud_div <= DIV_W'(`SCW_RST_BAUD);
        end
        else
        begin
            if (wr_c1)
            begin
                t8 <= wdata_in[`SCW_C1_T8];
                nine_bit <= wdata_in[`SCW_C1_NINE];
                wake_addr <= wdata_in[`SCW_C1_WAKE];
                sync_polarity <= wdata_in[`SCW_C1_POL];
                sync_phase <= wdata_in[`SCW_C1_PHA];
                final_bit_pulse_enable <= wdata_in[`SCW_C1_LBP];
            end
            if (wr_c2)
            begin
                tx_enable <= wdata_in[`SCW_C2_TE];
                rx_enable <= wdata_in[`SCW_C2_RE];
                send_break <= wdata_in[`SCW_C2_BRK];
            end
            if (wr_in && addr_in == `SCW_OFF_BAUD)
                baud_div <= wdata_in[DIV_W-1:0];
        end
    end
    // sleep: software sets or clears, hardware wake clears
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            receiver_sleep <= 1'b0;
        else if (wr_c2)
            receiver_sleep <= wdata_in[`SCW_C2_SLEEP];
        else if (wake_now)
            receiver_sleep <= 1'b0;
    end
    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_full_flag <= 1'b0;
            idle_flag <= 1'b0;
            overrun_flag <= 1'b0;
            noise_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            tc_flag <= 1'b0;
        end
        else
        begin
            rx_full_flag <= set_full | (rx_full_flag & ~rd_data);
            idle_flag <= set_idle | (idle_flag & ~rd_data);
            overrun_flag <= set_ovr | (overrun_flag & ~rd_data);
            noise_flag <= set_noise | (noise_flag & ~rd_data);
            framing_error_flag <= set_fe | (framing_error_flag & ~rd_data);
            tc_flag <= set_tc | (tc_flag & ~wr_data);
        end
    end
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rdata_out <= 8'h00;
            wr_ready_out <= 1'b0;
        end
        else
        begin
            wr_ready_out <= push_if.ready;
            unique case (addr_in)
                `SCW_OFF_DATA: rdata_out <= rx_holding;
                `SCW_OFF_CTL1: rdata_out <= {r8, t8, 1'b0, nine_bit,
                    wake_addr, sync_polarity, sync_phase, final_bit_pulse_enable};
                `SCW_OFF_CTL2: rdata_out <= {4'h0, tx_enable, rx_enable,
                    receiver_sleep, send_break};
                `SCW_OFF_FLAGS: rdata_out <= {~pop_if.valid, tc_flag,
                    rx_full_flag, idle_flag, overrun_flag, noise_flag,
                    framing_error_flag, 1'b0};
                `SCW_OFF_BAUD: rdata_out <= 8'(baud_div);
                default: rdata_out <= 8'h00;
            endcase
        end
    end
    // ********************************
    // receiver
    // ********************************
    scw_rx_state_t rx_state;
    logic [3:0] rt;
    logic [3:0] bit_idx;
    logic [1:0] smp;
    logic [1:0] lows;
    logic [8:0] rx_shift;
    logic frame_noise, seen_char;
    logic [7:0] idle_cnt;
    logic [3:0] idle_rt;
    logic [2:0] cur3;
    logic bitval, frame_end, brk, deliver;
    logic [7:0] rx_byte;
    assign cur3 = {smp, rx_serial_in};
    assign bitval = scw_maj3(cur3);
    assign frame_end = tick && rx_state == RX_BITS && rt == `SCW_RT_S10
        && bit_idx == 4'(nbits + 8'h01);
    assign rx_byte = nine_bit ? rx_shift[7:0] : rx_shift[8:1];
    assign brk = !bitval && rx_byte == 8'h00 && !(nine_bit && rx_shift[8]);
    assign deliver = frame_end && rx_enable
        && (!receiver_sleep || (wake_addr && rx_shift[8]));
    assign set_full = deliver && !rx_full_flag;
    assign set_ovr = deliver && rx_full_flag;
    assign set_noise = deliver && (frame_noise || !(&cur3 || ~|cur3));
    assign set_fe = deliver && !bitval;
    assign set_idle = tick && rx_serial_in && seen_char && rx_enable
        && !receiver_sleep && idle_cnt == (nbits + 8'h02);
    assign wake_now = receiver_sleep && ((frame_end && wake_addr && rx_shift[8])
        || (!wake_addr && tick && rx_serial_in
        && idle_cnt == (nbits + 8'h01) && idle_rt == `SCW_RT_LAST));
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_state <= RX_IDLE;
            rt <= 4'h0;
            bit_idx <= 4'h0;
            smp <= 2'h0;
            lows <= 2'h0;
            frame_noise <= 1'b0;
            rx_shift <= 9'h000;
        end
        else if (tick)
        begin
            smp <= cur3[1:0];
            rt <= rt + 4'h1;
            unique case (rx_state)
                RX_IDLE:
                    if (!rx_serial_in)
                    begin
                        rx_state <= RX_VERIFY;
                        rt <= 4'h1;
                        lows <= 2'h0;
                        frame_noise <= 1'b0;
                    end
                RX_VERIFY:
                begin
                    if (rt[0] == 1'b0 && !rx_serial_in)
                        lows <= lows + 2'h1;
                    if (rt[0] == 1'b0 && rx_serial_in)
                        frame_noise <= 1'b1;
                    if (rt == `SCW_RT_V7)
                    begin
                        bit_idx <= 4'h0;
                        if (lows + 2'(!rx_serial_in) >= 2'h2)
                            rx_state <= RX_BITS;
                        else
                            rx_state <= RX_IDLE;
                    end
                end
                RX_BITS:
                    if (rt == `SCW_RT_S10)
                    begin
                        if (!(&cur3 || ~|cur3))
                            frame_noise <= 1'b1;
                        if (bit_idx != 4'h0 && bit_idx <= 4'(nbits))
                            rx_shift <= {bitval, rx_shift[8:1]};
                        if (frame_end && bitval)
                            rx_state <= RX_IDLE;
                        else if (frame_end && brk)
                            rx_state <= RX_WAIT_HIGH;
                        else if (frame_end)
                        begin
                            rx_state <= RX_HOLD;
                            rx_shift[8] <= 1'b1;
                        end
                    end
                    else if (rt == `SCW_RT_LAST)
                        bit_idx <= bit_idx + 4'h1;
                RX_HOLD:
                    if (rt == `SCW_RT_LAST)
                    begin
                        rx_state <= rx_serial_in ? RX_IDLE : RX_VERIFY;
                        lows <= 2'h0;
                        frame_noise <= 1'b0;
                    end
                RX_WAIT_HIGH:
                    if (rx_serial_in)
                        rx_state <= RX_IDLE;
                default:
                    rx_state <= RX_IDLE;
            endcase
        end
    end
    // received word and idle line timing
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            rx_holding <= `SCW_RST_DATA;
            r8 <= 1'b0;
            idle_cnt <= 8'h00;
            idle_rt <= 4'h0;
            seen_char <= 1'b0;
        end
        else
        begin
            if (set_full)
            begin
                rx_holding <= rx_byte;
                r8 <= rx_shift[8];
            end
            if (deliver)
                seen_char <= 1'b1;
            else if (set_idle)
                seen_char <= 1'b0;
            if (tick && !rx_serial_in)
            begin
                idle_cnt <= 8'h00;
                idle_rt <= 4'h0;
            end
            else if (tick && idle_cnt != (nbits + 8'h02))
            begin
                idle_rt <= idle_rt + 4'h1;
                if (idle_rt == `SCW_RT_LAST)
                    idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end
    // ********************************
    // transmitter
    // ********************************
    scw_tx_state_t tx_state;
    logic [3:0] tx_rt;
    logic [3:0] tx_idx;
    logic [8:0] tx_shift;
    logic tx_bit_end, sync_active, te_rise;
    assign tx_bit_end = tick && tx_rt == `SCW_RT_LAST;
    assign pop_if.ready = tx_bit_end && tx_state == TX_IDLE && tx_enable
        && !pre_req && !send_break;
    assign set_tc = tx_bit_end && ((tx_state == TX_STOP && !pop_if.valid)
        || (tx_state == TX_PRE && tx_idx == 4'(nbits + 8'h01)));
    assign te_rise = wr_c2 && wdata_in[`SCW_C2_TE] && !tx_enable;
    assign sync_active = tx_state == TX_DATA
        && (tx_idx != 4'(nbits - 8'h01) || final_bit_pulse_enable)
        && (sync_phase ? tx_rt < `SCW_RT_HALF : tx_rt >= `SCW_RT_HALF);
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            pre_req <= 1'b0;
        else
            pre_req <= te_rise | (pre_req
                & ~(tx_bit_end && (tx_state == TX_IDLE || tx_state == TX_OFF)));
    end
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_state <= TX_OFF;
            tx_rt <= 4'h0;
            tx_idx <= 4'h0;
            tx_shift <= 9'h1FF;
        end
        else
        begin
            if (tick)
                tx_rt <= tx_rt + 4'h1;
            if (tx_bit_end)
            begin
                tx_idx <= tx_idx + 4'h1;
                unique case (tx_state)
                    TX_OFF:
                        if (tx_enable)
                        begin
                            tx_state <= TX_PRE;
                            tx_idx <= 4'h0;
                        end
                    TX_PRE:
                        if (tx_idx == 4'(nbits + 8'h01))
                            tx_state <= TX_IDLE;
                    TX_IDLE:
                    begin
                        tx_idx <= 4'h0;
                        if (!tx_enable)
                            tx_state <= TX_OFF;
                        else if (pre_req)
                            tx_state <= TX_PRE;
                        else if (send_break)
                            tx_state <= TX_BREAK;
                        else if (pop_if.valid)
                        begin
                            tx_shift <= pop_if.data;
                            tx_state <= TX_START;
                        end
                    end
                    TX_START:
                    begin
                        tx_state <= TX_DATA;
                        tx_idx <= 4'h0;
                    end
                    TX_DATA:
                    begin
                        tx_shift <= {1'b1, tx_shift[8:1]};
                        if (tx_idx == 4'(nbits - 8'h01))
                            tx_state <= TX_STOP;
                    end
                    TX_STOP:
                        tx_state <= TX_IDLE;
                    TX_BREAK:
                        if (!send_break)
                            tx_state <= TX_IDLE;
                    default:
                        tx_state <= TX_OFF;
                endcase
            end
        end
    end
    // pin drivers, all registered
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_data_out <= 1'b1;
            tx_data_oe_out <= 1'b0;
            sync_clk_out <= 1'b0;
            sync_clk_oe_out <= 1'b0;
        end
        else
        begin
            tx_data_oe_out <= tx_state != TX_OFF;
            sync_clk_oe_out <= tx_state != TX_OFF;
            tx_data_out <= !(tx_state == TX_START || tx_state == TX_BREAK)
                && (tx_state != TX_DATA || tx_shift[0]);
            sync_clk_out <= sync_polarity ^ sync_active;
        end
    end
    // ********************************
    // checks
    // ********************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_sleep_full_gate: assert property ($rose(rx_full_flag) && $past(receiver_sleep)
        |-> $past(wake_addr) && !receiver_sleep) else $error("full set while asleep");
    a_sleep_idle_gate: assert property ($rose(idle_flag) |-> !$past(receiver_sleep))
        else $error("idle set while asleep");
    a_idle_wake_clear: assert property (wake_now && !wr_c2 |=> !receiver_sleep)
        else $error("wake did not clear sleep");
    a_start_reject: assert property (tick && rx_state == RX_VERIFY && rt == `SCW_RT_V7
        && lows == 2'h0 && rx_serial_in |=> rx_state == RX_IDLE)
        else $error("weak start accepted");
    a_break_wait: assert property (rx_state == RX_WAIT_HIGH && !rx_serial_in
        |=> rx_state == RX_WAIT_HIGH) else $error("start before high after break");
    a_sync_quiet: assert property ($past(tx_state) != TX_DATA
        |-> sync_clk_out == $past(sync_polarity)) else $error("sync pulse outside data");
    a_off_float: assert property (tx_state == TX_OFF |=> !tx_data_oe_out && !sync_clk_oe_out)
        else $error("pins driven while off");
    a_start_low: assert property (tx_state == TX_START |=> !tx_data_out)
        else $error("start bit not low");
    a_load_boundary: assert property (pop_if.valid && pop_if.ready
        |=> tx_state == TX_START && tx_rt == 4'h0) else $error("load off frame edge");
    c_frame_in: cover property (set_full && !noise_flag);
    c_addr_wake: cover property (wake_now && wake_addr);
    c_sync_pulse: cover property ($rose(sync_clk_out) && !sync_polarity);
endmodule : scw_core

// *** dv/scw_line_model.sv ***
// remote serial partner: sends frames to the block, captures its output
// assumes baud divisor 0, so one bit lasts sixteen clocks
`timescale 1ns/1ps
module scw_line_model #(
    parameter int BIT_CLKS = 16
)(
    input wire logic clk_in,
    input wire logic tx_wire_in,
    output logic rx_line_out,
    output logic [7:0] got_out,
    output int got_cnt_out
);
    initial
    begin
        rx_line_out = 1'b1;
        got_out = 8'h00;
        got_cnt_out = 0;
    end
    // one frame out: low start, lsb first, high stop, line rests high
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_in) #2;
            rx_line_out = (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i-1]);
            repeat (BIT_CLKS - 1) @(posedge clk_in);
        end
    endtask : send
    // capture: mid-bit samples at a fixed sixteen clocks per bit
    initial
    forever
    begin
        @(negedge tx_wire_in);
        repeat (BIT_CLKS / 2) @(posedge clk_in);
        if (tx_wire_in === 1'b0)
        begin
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CLKS) @(posedge clk_in);
                got_out[i] = tx_wire_in;
            end
            repeat (BIT_CLKS) @(posedge clk_in);
            got_cnt_out++;
        end
    end
endmodule : scw_line_model

// *** dv/testbench.sv ***
// self-checking bench for the serial wake/sync block
// assumes the line partner model and a pulled-up transmit line
`timescale 1ns/1ps
module testbench;
    import scw_pkg::*;
    logic clk_in = 1'b0, reset_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, got;
    logic wr_ready_out, tx_data_out, tx_data_oe_out, sync_clk_out, sync_clk_oe_out, rx_line;
    wire tx_wire = tx_data_oe_out ? tx_data_out : 1'b1;
    int n_errors = 0, cmp_count = 0, got_cnt, pulses = 0, n;
    scw_core scw_core_inst (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .wr_ready_out(wr_ready_out), .rx_serial_in(rx_line), .tx_data_out(tx_data_out),
        .tx_data_oe_out(tx_data_oe_out), .sync_clk_out(sync_clk_out),
        .sync_clk_oe_out(sync_clk_oe_out));
    scw_line_model scw_line_model_inst (.clk_in(clk_in), .tx_wire_in(tx_wire),
        .rx_line_out(rx_line), .got_out(got), .got_cnt_out(got_cnt));
    initial
    forever
        #25 clk_in = ~clk_in;
    always @(posedge sync_clk_out)
        pulses++;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_in) #2;
        addr_in = a;
        wr_in = w;
        rd_in = ~w;
        wdata_in = d;
        @(posedge clk_in) #2;
        wr_in = 1'b0;
        rd_in = 1'b0;
    endtask : bus
    // transmit a byte, watch line and sync clock with polarity 0, phase 0
    task automatic scen_tx();
        n = got_cnt;
        pulses = 0;
        bus(8'h11, 1'b1, 8'hA5);
        for (int i = 0; i < 1000 && got_cnt == n; i++)
            @(posedge clk_in);
        if (got_cnt == n)
        begin
            n_errors++;
            end_of_test();
        end
        chk(got, 8'hA5);
        chk(8'(pulses), 8'h07);
        chk({7'h00, sync_clk_out}, 8'h00);
    endtask : scen_tx
    // receive while asleep in address-mark mode, then wake on address
    task automatic scen_rx_wake();
        scw_line_model_inst.send(8'h3C);
        bus(8'h10, 1'b0, 8'h00);
        chk({7'h00, rdata_out[5]}, 8'h01);
        bus(8'h11, 1'b0, 8'h00);
        chk(rdata_out, 8'h3C);
        bus(8'h0E, 1'b1, 8'h08);
        bus(8'h0F, 1'b1, 8'h0E);
        scw_line_model_inst.send(8'h12);
        bus(8'h10, 1'b0, 8'h00);
        chk({7'h00, rdata_out[5]}, 8'h00);
        scw_line_model_inst.send(8'h81);
        bus(8'h10, 1'b0, 8'h00);
        chk({7'h00, rdata_out[5]}, 8'h01);
    endtask : scen_rx_wake
    // nine-bit frame, polarity 1, phase 1, final-bit pulse on
    task automatic scen_tx9();
        bus(8'h0F, 1'b1, 8'h04);
        repeat (40) @(posedge clk_in);
        bus(8'h0E, 1'b1, 8'h57);
        bus(8'h0F, 1'b1, 8'h0C);
        n = got_cnt;
        pulses = 0;
        bus(8'h11, 1'b1, 8'h3C);
        for (int i = 0; i < 1000 && got_cnt == n; i++)
            @(posedge clk_in);
        if (got_cnt == n)
        begin
            n_errors++;
            end_of_test();
        end
        repeat (20) @(posedge clk_in);
        chk(got, 8'h3C);
        chk(8'(pulses), 8'h09);
        chk({7'h00, sync_clk_out}, 8'h01);
        bus(8'h0F, 1'b1, 8'h04);
        bus(8'h0E, 1'b1, 8'h00);
    endtask : scen_tx9
    // idle-line wake: two-frame message while asleep, then an idle gap
    task automatic scen_idle_wake();
        bus(8'h11, 1'b0, 8'h00);
        bus(8'h0E, 1'b1, 8'h00);
        bus(8'h0F, 1'b1, 8'h0E);
        scw_line_model_inst.send(8'h55);
        scw_line_model_inst.send(8'h66);
        bus(8'h10, 1'b0, 8'h00);
        chk({7'h00, rdata_out[5]}, 8'h00);
        repeat (200) @(posedge clk_in);
        bus(8'h0F, 1'b0, 8'h00);
        chk(rdata_out, 8'h0C);
        scw_line_model_inst.send(8'h5A);
        bus(8'h11, 1'b0, 8'h00);
        chk(rdata_out, 8'h5A);
    endtask : scen_idle_wake
    initial
    begin
        repeat (20) @(posedge clk_in);
        #2 reset_in = 1'b0;
        bus(8'h11, 1'b0, 8'h00);
        chk(rdata_out, 8'h00);
        chk({7'h00, wr_ready_out}, 8'h01);
        bus(8'h0D, 1'b1, 8'h00);
        bus(8'h0E, 1'b1, 8'h00);
        bus(8'h0F, 1'b1, 8'h0C);
        scen_tx();
        scen_tx9();
        scen_rx_wake();
        scen_idle_wake();
        bus(8'h0F, 1'b1, 8'h04);
        for (int i = 0; i < 400 && tx_data_oe_out !== 1'b0; i++)
            @(posedge clk_in);
        chk({6'h00, tx_data_oe_out, sync_clk_oe_out}, 8'h00);
        end_of_test();
    end
endmodule : testbench
